/* inc/crtv_pkg.sv */
`default_nettype none
package crtv_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 32;

   // Register byte addresses.
   localparam logic [31:0] ADDR_VERT_SYNC_END = 32'hc000_0000;
   localparam logic [31:0] ADDR_HORIZ_SYNC_END = 32'hc000_0010;
   localparam logic [31:0] ADDR_VERT_BLANK_END = 32'hc000_0020;
   localparam logic [31:0] ADDR_HORIZ_BLANK_END = 32'hc000_0030;
   localparam logic [31:0] ADDR_VERT_BLANK_START = 32'hc000_0040;
   localparam logic [31:0] ADDR_HORIZ_BLANK_START = 32'hc000_0050;
   localparam logic [31:0] ADDR_VERT_TOTAL = 32'hc000_0060;
   localparam logic [31:0] ADDR_HORIZ_TOTAL = 32'hc000_0070;
   localparam logic [31:0] ADDR_DISPLAY_CONTROL = 32'hc000_0080;
   localparam logic [31:0] ADDR_VERT_COUNTER = 32'hc000_01c0;
   localparam logic [31:0] ADDR_HORIZ_COUNTER = 32'hc000_01d0;
   localparam logic [31:0] ADDR_SERRATION_END = 32'hc000_0270;
   localparam logic [31:0] ADDR_VERT_PRESET = 32'hc000_0300;
   localparam logic [31:0] ADDR_HORIZ_PRESET = 32'hc000_0310;
   localparam logic [31:0] ADDR_SERIAL_TAP_COUNT = 32'hc000_0320;

   // Display control bit positions.
   localparam int HSYNC_DIR_BIT = 0;
   localparam int VSYNC_DIR_BIT = 1;
   localparam int COMPOSITE_SYNC_N_DIR_BIT = 2;
   localparam int COMP_DISABLE_BIT = 3;
   localparam int SPLIT_SERIAL_BIT = 6;
   localparam int NONINTERLACE_BIT = 14;
   localparam int VIDEO_EN_BIT = 15;

   // Reset values and counter constants.
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_STEP = 16'h0001;
endpackage : crtv_pkg
`default_nettype wire

/* inc/crtv_cfg_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface crtv_cfg_if;
   logic [15:0] vSyncEnd, hSyncEnd, vBlankEnd, hBlankEnd;
   logic [15:0] vBlankStart, hBlankStart, vert_frame_total, horiz_line_total;
   logic [15:0] ctrl, serrEnd, vPreset, hPreset, wrData;
   logic hCountWr, vCountWr;
   logic [15:0] horiz_dot_counter, vert_line_counter, tapCount;
   modport regs(output vSyncEnd, hSyncEnd, vBlankEnd, hBlankEnd,
      vBlankStart, hBlankStart, vert_frame_total, horiz_line_total, ctrl, serrEnd,
      vPreset, hPreset, wrData, hCountWr, vCountWr,
      input horiz_dot_counter, vert_line_counter, tapCount);
   modport core(input vSyncEnd, hSyncEnd, vBlankEnd, hBlankEnd,
      vBlankStart, hBlankStart, vert_frame_total, horiz_line_total, ctrl, serrEnd,
      vPreset, hPreset, wrData, hCountWr, vCountWr,
      output horiz_dot_counter, vert_line_counter, tapCount);
endinterface : crtv_cfg_if
`default_nettype wire

/* hw/crtv_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module crtv_sync #(
   parameter logic INIT = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pin and its resolved level and edges
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic last;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= INIT;
         level <= INIT;
         last <= INIT;
      end else begin
         meta <= pin;
         level <= meta;
         last <= level;
      end
   end

   assign rise = level & ~last;
   assign fall = ~level & last;
endmodule : crtv_sync
`default_nettype wire

/* hw/crtv_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module crtv_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [31:0] addr,
   input wire logic [15:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [15:0] rdData,
   // Configuration towards the timing core
   crtv_cfg_if.regs cfg
);
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg.vSyncEnd <= crtv_pkg::REG_RESET;
         cfg.hSyncEnd <= crtv_pkg::REG_RESET;
         cfg.vBlankEnd <= crtv_pkg::REG_RESET;
         cfg.hBlankEnd <= crtv_pkg::REG_RESET;
         cfg.vBlankStart <= crtv_pkg::REG_RESET;
         cfg.hBlankStart <= crtv_pkg::REG_RESET;
         cfg.vert_frame_total <= crtv_pkg::REG_RESET;
         cfg.horiz_line_total <= crtv_pkg::REG_RESET;
         cfg.ctrl <= crtv_pkg::CTRL_RESET;
         cfg.serrEnd <= crtv_pkg::REG_RESET;
         cfg.vPreset <= crtv_pkg::REG_RESET;
         cfg.hPreset <= crtv_pkg::REG_RESET;
      end else if (wrEn) begin
         unique case (addr)
            crtv_pkg::ADDR_VERT_SYNC_END: cfg.vSyncEnd <= wrData;
            crtv_pkg::ADDR_HORIZ_SYNC_END: cfg.hSyncEnd <= wrData;
            crtv_pkg::ADDR_VERT_BLANK_END: cfg.vBlankEnd <= wrData;
            crtv_pkg::ADDR_HORIZ_BLANK_END: cfg.hBlankEnd <= wrData;
            crtv_pkg::ADDR_VERT_BLANK_START: cfg.vBlankStart <= wrData;
            crtv_pkg::ADDR_HORIZ_BLANK_START: cfg.hBlankStart <= wrData;
            crtv_pkg::ADDR_VERT_TOTAL: cfg.vert_frame_total <= wrData;
            crtv_pkg::ADDR_HORIZ_TOTAL: cfg.horiz_line_total <= wrData;
            crtv_pkg::ADDR_DISPLAY_CONTROL: cfg.ctrl <= wrData;
            crtv_pkg::ADDR_SERRATION_END: cfg.serrEnd <= wrData;
            crtv_pkg::ADDR_VERT_PRESET: cfg.vPreset <= wrData;
            crtv_pkg::ADDR_HORIZ_PRESET: cfg.hPreset <= wrData;
            default: ;
         endcase
      end
   end

   // Counter writes are handed to the core, which owns the counters.
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg.hCountWr <= 1'b0;
         cfg.vCountWr <= 1'b0;
         cfg.wrData <= crtv_pkg::REG_RESET;
      end else begin
         cfg.hCountWr <= wrEn && addr == crtv_pkg::ADDR_HORIZ_COUNTER;
         cfg.vCountWr <= wrEn && addr == crtv_pkg::ADDR_VERT_COUNTER;
         cfg.wrData <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !rdEn) begin
         rdData <= crtv_pkg::REG_RESET;
      end else begin
         unique case (addr)
            crtv_pkg::ADDR_VERT_SYNC_END: rdData <= cfg.vSyncEnd;
            crtv_pkg::ADDR_HORIZ_SYNC_END: rdData <= cfg.hSyncEnd;
            crtv_pkg::ADDR_VERT_BLANK_END: rdData <= cfg.vBlankEnd;
            crtv_pkg::ADDR_HORIZ_BLANK_END: rdData <= cfg.hBlankEnd;
            crtv_pkg::ADDR_VERT_BLANK_START: rdData <= cfg.vBlankStart;
            crtv_pkg::ADDR_HORIZ_BLANK_START: rdData <= cfg.hBlankStart;
            crtv_pkg::ADDR_VERT_TOTAL: rdData <= cfg.vert_frame_total;
            crtv_pkg::ADDR_HORIZ_TOTAL: rdData <= cfg.horiz_line_total;
            crtv_pkg::ADDR_DISPLAY_CONTROL: rdData <= cfg.ctrl;
            crtv_pkg::ADDR_VERT_COUNTER: rdData <= cfg.vert_line_counter;
            crtv_pkg::ADDR_HORIZ_COUNTER: rdData <= cfg.horiz_dot_counter;
            crtv_pkg::ADDR_SERRATION_END: rdData <= cfg.serrEnd;
            crtv_pkg::ADDR_VERT_PRESET: rdData <= cfg.vPreset;
            crtv_pkg::ADDR_HORIZ_PRESET: rdData <= cfg.hPreset;
            crtv_pkg::ADDR_SERIAL_TAP_COUNT: rdData <= cfg.tapCount;
            default: rdData <= crtv_pkg::REG_RESET;
         endcase
      end
   end
endmodule : crtv_regs
`default_nettype wire

/* hw/crtv_timing_gen.sv */
// Function
// - Timing runs from the external dot clock.
// - Blank pin always output, composite or vertical.
// - Shared pin: composite sync or horizontal blank.
// - Horizontal sync direction bit zero.
// - Vertical sync direction bit one.
// - Shift clock tracks the serial tap point.
// - Horizontal counter counts dot clocks per line.
// - Horizontal sync ends at sync end point.
// - Serration pulse ends at serration end point.
// - Horizontal blank between start and end points.
// - Line total sets length, starts horizontal sync.
// - External sync start loads horizontal preset.
// - Vertical counter counts scan lines.
// - Vertical sync ends at sync end line.
// - Vertical blank between start and end lines.
// - Frame total sets lines, starts vertical sync.
// - External vertical start loads vertical preset.
// - Video disabled forces blanking, stops display.
// - Line total is periods minus one.
// - Count on falling dot edge, wrap after total.
`timescale 1ns/1ns
`default_nettype none
module crtv_timing_gen (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [31:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   // Video clocks from the monitor side
   input wire logic videoDotClock,
   input wire logic vramShiftClock,
   // Horizontal sync pin
   input wire logic hsyncInN,
   output logic hsyncOutN,
   output logic hsyncOeN,
   // Vertical sync pin
   input wire logic vsyncInN,
   output logic vsyncOutN,
   output logic vsyncOeN,
   // Shared composite sync or horizontal blank pin
   input wire logic compSyncInN,
   output logic compSyncOutN,
   output logic compSyncOeN,
   // Composite or vertical blank pin
   output logic compositeBlankN
);
   crtv_cfg_if cfg();

   logic dotFall;
   logic hsFall;
   logic vsFall;
   logic csFall;
   logic shiftRise;

   logic videoEn;
   logic hsyncDir;
   logic vsyncDir;
   logic csyncDir;
   logic compDisable;
   logic splitSerial;
   logic compExt;
   logic earlyPulse;

   logic dotTick;
   logic hLoad;
   logic vLoad;
   logic hWrap;
   logic vWrap;
   logic serrSeen;

   logic hsyncOn;
   logic serrOn;
   logic hBlankOn;
   logic vsyncOn;
   logic vBlankOn;
   logic hBlankAct;
   logic vBlankAct;
   logic compActive;

   crtv_regs regFile (
      .clk(mclk),
      .rst(rst),
      .addr(regAddr),
      .wrData(regWrData),
      .wrEn(regWr),
      .rdEn(regRd),
      .rdData(regRdData),
      .cfg(cfg.regs)
   );

   // The dot clock resets high so a clock parked high gives no edge.
   crtv_sync #(.INIT(1'b1)) dotSync (
      .clk(mclk),
      .rst(rst),
      .pin(videoDotClock),
      .level(),
      .rise(),
      .fall(dotFall)
   );

   crtv_sync #(.INIT(1'b1)) hsSync (
      .clk(mclk),
      .rst(rst),
      .pin(hsyncInN),
      .level(),
      .rise(),
      .fall(hsFall)
   );

   crtv_sync #(.INIT(1'b1)) vsSync (
      .clk(mclk),
      .rst(rst),
      .pin(vsyncInN),
      .level(),
      .rise(),
      .fall(vsFall)
   );

   crtv_sync #(.INIT(1'b1)) csSync (
      .clk(mclk),
      .rst(rst),
      .pin(compSyncInN),
      .level(),
      .rise(),
      .fall(csFall)
   );

   crtv_sync #(.INIT(1'b0)) shiftSync (
      .clk(mclk),
      .rst(rst),
      .pin(vramShiftClock),
      .level(),
      .rise(shiftRise),
      .fall()
   );

   assign videoEn = cfg.ctrl[crtv_pkg::VIDEO_EN_BIT];
   assign hsyncDir = cfg.ctrl[crtv_pkg::HSYNC_DIR_BIT];
   assign vsyncDir = cfg.ctrl[crtv_pkg::VSYNC_DIR_BIT];
   assign csyncDir = cfg.ctrl[crtv_pkg::COMPOSITE_SYNC_N_DIR_BIT];
   assign compDisable = cfg.ctrl[crtv_pkg::COMP_DISABLE_BIT];
   assign splitSerial = cfg.ctrl[crtv_pkg::SPLIT_SERIAL_BIT];

   // Timing steps once per falling edge of the dot clock.
   assign dotTick = dotFall && videoEn;
   assign compExt = !compDisable && !csyncDir;

   // A composite sync edge before horizontal blank is a serration.
   assign earlyPulse = cfg.horiz_dot_counter < cfg.hBlankStart;

   // External sync starts reload the counters to absorb skew.
   assign hLoad = videoEn && ((!hsyncDir && hsFall) ||
      (compExt && csFall && !earlyPulse));
   assign vLoad = videoEn && ((!vsyncDir && vsFall) ||
      (compExt && csFall && earlyPulse && !serrSeen));
   assign hWrap = dotTick && !hLoad &&
      cfg.horiz_dot_counter == cfg.horiz_line_total;
   assign vWrap = hWrap && cfg.vert_line_counter == cfg.vert_frame_total;

   always_ff @(posedge mclk) begin
      if (rst || !videoEn) begin
         cfg.horiz_dot_counter <= crtv_pkg::COUNT_ZERO;
      end else if (cfg.hCountWr) begin
         cfg.horiz_dot_counter <= cfg.wrData;
      end else if (hLoad) begin
         cfg.horiz_dot_counter <= cfg.hPreset;
      end else if (hWrap) begin
         cfg.horiz_dot_counter <= crtv_pkg::COUNT_ZERO;
      end else if (dotTick) begin
         cfg.horiz_dot_counter <= cfg.horiz_dot_counter + crtv_pkg::COUNT_STEP;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || !videoEn) begin
         cfg.vert_line_counter <= crtv_pkg::COUNT_ZERO;
      end else if (cfg.vCountWr) begin
         cfg.vert_line_counter <= cfg.wrData;
      end else if (vLoad) begin
         cfg.vert_line_counter <= cfg.vPreset;
      end else if (vWrap) begin
         cfg.vert_line_counter <= crtv_pkg::COUNT_ZERO;
      end else if (hWrap) begin
         cfg.vert_line_counter <= cfg.vert_line_counter + crtv_pkg::COUNT_STEP;
      end
   end

   // Only the first serration of a frame may reload the line count.
   always_ff @(posedge mclk) begin
      if (rst || !videoEn) begin
         serrSeen <= 1'b0;
      end else if (vLoad) begin
         serrSeen <= 1'b1;
      end else if (hWrap && cfg.vert_line_counter == cfg.vBlankStart) begin
         serrSeen <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || !videoEn) begin
         hsyncOn <= 1'b0;
         serrOn <= 1'b0;
         hBlankOn <= 1'b0;
      end else if (dotTick && !hLoad) begin
         if (cfg.horiz_dot_counter == cfg.horiz_line_total) begin
            hsyncOn <= 1'b1;
            serrOn <= 1'b1;
         end else begin
            if (cfg.horiz_dot_counter == cfg.hSyncEnd) begin
               hsyncOn <= 1'b0;
            end
            if (cfg.horiz_dot_counter == cfg.serrEnd) begin
               serrOn <= 1'b0;
            end
         end
         if (cfg.horiz_dot_counter == cfg.hBlankStart) begin
            hBlankOn <= 1'b1;
         end else if (cfg.horiz_dot_counter == cfg.hBlankEnd) begin
            hBlankOn <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || !videoEn) begin
         vsyncOn <= 1'b0;
         vBlankOn <= 1'b0;
      end else if (hWrap) begin
         if (cfg.vert_line_counter == cfg.vert_frame_total) begin
            vsyncOn <= 1'b1;
         end else if (cfg.vert_line_counter == cfg.vSyncEnd) begin
            vsyncOn <= 1'b0;
         end
         if (cfg.vert_line_counter == cfg.vBlankStart) begin
            vBlankOn <= 1'b1;
         end else if (cfg.vert_line_counter == cfg.vBlankEnd) begin
            vBlankOn <= 1'b0;
         end
      end
   end

   // The tap count is only meaningful while the shift clock is idle in
   // blanking, so it is cleared at each line wrap.
   always_ff @(posedge mclk) begin
      if (rst || !splitSerial || hWrap) begin
         cfg.tapCount <= crtv_pkg::COUNT_ZERO;
      end else if (shiftRise) begin
         cfg.tapCount <= cfg.tapCount + crtv_pkg::COUNT_STEP;
      end
   end

   assign hBlankAct = !videoEn || hBlankOn;
   assign vBlankAct = !videoEn || vBlankOn;
   assign compActive = videoEn && (vsyncOn ? serrOn : hsyncOn);

   // Pin levels and enables leave from flops to keep the pins glitch free.
   always_ff @(posedge mclk) begin
      if (rst) begin
         hsyncOutN <= 1'b1;
         hsyncOeN <= 1'b1;
         vsyncOutN <= 1'b1;
         vsyncOeN <= 1'b1;
         compSyncOutN <= 1'b1;
         compSyncOeN <= 1'b1;
         compositeBlankN <= 1'b0;
      end else begin
         hsyncOutN <= !(videoEn && hsyncOn);
         hsyncOeN <= !hsyncDir;
         vsyncOutN <= !(videoEn && vsyncOn);
         vsyncOeN <= !vsyncDir;
         compSyncOutN <= compDisable ? !hBlankAct : !compActive;
         compSyncOeN <= !(compDisable || csyncDir);
         compositeBlankN <= compDisable ? !vBlankAct :
            !(vBlankAct || hBlankAct);
      end
   end

   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence lineEnd;
      dotTick && !hLoad && !cfg.hCountWr && cfg.horiz_dot_counter == cfg.horiz_line_total;
   endsequence

   sequence syncEndPoint;
      dotTick && !hLoad && cfg.horiz_dot_counter == cfg.hSyncEnd &&
         cfg.horiz_dot_counter != cfg.horiz_line_total;
   endsequence

   sequence frameEnd;
      hWrap && !vLoad && !cfg.vCountWr && cfg.vert_line_counter == cfg.vert_frame_total;
   endsequence

   horiz_dot_counter_wrap_a: assert property (
      lineEnd |=> cfg.horiz_dot_counter == crtv_pkg::COUNT_ZERO)
      else $error("line counter did not clear after total");

   horiz_dot_counter_step_a: assert property (
      dotTick && !hLoad && !cfg.hCountWr && cfg.horiz_dot_counter != cfg.horiz_line_total
      |=> cfg.horiz_dot_counter == $past(cfg.horiz_dot_counter) + crtv_pkg::COUNT_STEP)
      else $error("line counter did not advance on dot edge");

   horiz_dot_counter_hold_a: assert property (
      videoEn && !dotFall && !hLoad && !cfg.hCountWr
      |=> $stable(cfg.horiz_dot_counter))
      else $error("line counter moved without a dot edge");

   hpreset_load_a: assert property (
      hLoad && !cfg.hCountWr |=> cfg.horiz_dot_counter == $past(cfg.hPreset))
      else $error("external sync did not load horizontal preset");

   vpreset_load_a: assert property (
      vLoad && !cfg.vCountWr |=> cfg.vert_line_counter == $past(cfg.vPreset))
      else $error("external sync did not load vertical preset");

   vert_line_counter_wrap_a: assert property (
      frameEnd |=> cfg.vert_line_counter == crtv_pkg::COUNT_ZERO)
      else $error("frame counter did not clear after total");

   hsync_start_a: assert property (
      lineEnd |=> hsyncOn ##1 !hsyncOutN)
      else $error("horizontal sync did not start at line total");

   hsync_end_a: assert property (
      syncEndPoint |=> !hsyncOn ##1 hsyncOutN)
      else $error("horizontal sync did not end at end point");

   vsync_start_a: assert property (
      frameEnd |=> vsyncOn ##1 !vsyncOutN)
      else $error("vertical sync did not start at frame total");

   video_off_a: assert property (
      !videoEn ##1 !videoEn |-> !compositeBlankN && hsyncOutN)
      else $error("disabled video did not force blanking");

   hsync_dir_a: assert property (
      ##1 hsyncOeN == !$past(hsyncDir))
      else $error("horizontal sync direction not followed");

   vsync_dir_a: assert property (
      ##1 vsyncOeN == !$past(vsyncDir))
      else $error("vertical sync direction not followed");

   shared_dir_a: assert property (
      compDisable || csyncDir |=> !compSyncOeN)
      else $error("shared sync pin not driven as output");

   blank_vert_a: assert property (
      compDisable && vBlankOn |=> !compositeBlankN)
      else $error("vertical blank not shown on blank pin");

endmodule : crtv_timing_gen
`default_nettype wire

/* tb/crtv_monitor_model.sv */
`timescale 1ns/1ns
`default_nettype none
module crtv_monitor_model (
   // Pin drive from the device
   input wire logic hsyncOutN,
   input wire logic hsyncOeN,
   input wire logic vsyncOutN,
   input wire logic vsyncOeN,
   input wire logic compSyncOutN,
   input wire logic compSyncOeN,
   // Sync pulse requests from the bench
   input wire logic hReq,
   input wire logic vReq,
   // Monitor side pins
   output logic dotClk,
   output logic shiftClk,
   output logic hPin,
   output logic vPin,
   output logic cPin
);
   logic hLow = 1'b0;
   logic vLow = 1'b0;
   // Parked high until it starts, since a long low level is unsafe.
   initial begin
      dotClk = 1'b1;
      #13;
      forever #160 dotClk = ~dotClk;
   end
   // Midline reload is not used here, so the shift clock stays low.
   assign shiftClk = 1'b0;
   // External sync pulses start on a dot rising edge.
   always @(posedge dotClk) begin
      hLow <= hReq;
      vLow <= vReq;
   end
   // Sync lines carry pull-ups, so an undriven line reads high.
   assign hPin = !hsyncOeN ? hsyncOutN : !hLow;
   assign vPin = !vsyncOeN ? vsyncOutN : !vLow;
   assign cPin = !compSyncOeN ? compSyncOutN : 1'b1;
endmodule : crtv_monitor_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] regAddr = 32'h0000_0000;
   logic [15:0] regWrData = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic hReq = 1'b0;
   logic vReq = 1'b0;
   logic [15:0] regRdData;
   logic dotClk, shiftClk, hPin, vPin, cPin;
   logic hsyncOutN, hsyncOeN, vsyncOutN, vsyncOeN;
   logic compSyncOutN, compSyncOeN, compositeBlankN;
   int fails = 0;
   int tests_run = 0;

   always #20 mclk = ~mclk;

   crtv_timing_gen crtv_timing_gen_i (.mclk(mclk), .rst(rst),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .videoDotClock(dotClk),
      .vramShiftClock(shiftClk), .hsyncInN(hPin), .hsyncOutN(hsyncOutN),
      .hsyncOeN(hsyncOeN), .vsyncInN(vPin), .vsyncOutN(vsyncOutN),
      .vsyncOeN(vsyncOeN), .compSyncInN(cPin),
      .compSyncOutN(compSyncOutN), .compSyncOeN(compSyncOeN),
      .compositeBlankN(compositeBlankN));

   crtv_monitor_model crtv_monitor_model_i (.hsyncOutN(hsyncOutN),
      .hsyncOeN(hsyncOeN), .vsyncOutN(vsyncOutN), .vsyncOeN(vsyncOeN),
      .compSyncOutN(compSyncOutN), .compSyncOeN(compSyncOeN),
      .hReq(hReq), .vReq(vReq), .dotClk(dotClk), .shiftClk(shiftClk),
      .hPin(hPin), .vPin(vPin), .cPin(cPin));

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [15:0] d);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask : rd

   function automatic logic sig(input int idx);
      case (idx)
         0: return hsyncOutN;
         1: return vsyncOutN;
         2: return compSyncOutN;
         4: return hPin;
         5: return vPin;
         default: return compositeBlankN;
      endcase
   endfunction : sig

   // Bounded wait for a level; a hang ends the run with a failure.
   task automatic wait_lvl(input int idx, input logic lvl, output int n);
      n = 0;
      while (sig(idx) !== lvl) begin
         @(posedge mclk);
         #1;
         n++;
         if (n > 2000) begin
            chk("wait for level", {15'h0, lvl}, {15'h0, sig(idx)});
            give_verdict();
         end
      end
   endtask : wait_lvl

   // Low width and period of one pin, in system clock cycles.
   task automatic measure(input int idx, input int lowW, input int per);
      int a;
      int b;
      wait_lvl(idx, 1'b1, a);
      wait_lvl(idx, 1'b0, a);
      wait_lvl(idx, 1'b1, a);
      wait_lvl(idx, 1'b0, b);
      chk("low width", lowW[15:0], a[15:0]);
      chk("period", per[15:0], a[15:0] + b[15:0]);
   endtask : measure

   task automatic t_disabled();
      logic [15:0] d;
      for (int i = 0; i < 4; i++) begin
         repeat (50) @(posedge mclk);
         #1;
         chk("idle pins", 16'h003f, {9'h0, compositeBlankN,
            hsyncOutN, vsyncOutN, compSyncOutN, hsyncOeN, vsyncOeN,
            compSyncOeN});
      end
      rd(crtv_pkg::ADDR_HORIZ_COUNTER, d);
      chk("horiz counter", 16'h0000, d);
      rd(crtv_pkg::ADDR_VERT_COUNTER, d);
      chk("vert counter", 16'h0000, d);
   endtask : t_disabled

   task automatic t_regs();
      logic [31:0] adr [12] = '{crtv_pkg::ADDR_VERT_SYNC_END,
         crtv_pkg::ADDR_HORIZ_SYNC_END, crtv_pkg::ADDR_VERT_BLANK_END,
         crtv_pkg::ADDR_HORIZ_BLANK_END, crtv_pkg::ADDR_VERT_BLANK_START,
         crtv_pkg::ADDR_HORIZ_BLANK_START, crtv_pkg::ADDR_VERT_TOTAL,
         crtv_pkg::ADDR_HORIZ_TOTAL, crtv_pkg::ADDR_SERRATION_END,
         crtv_pkg::ADDR_VERT_PRESET, crtv_pkg::ADDR_HORIZ_PRESET,
         32'hc000_0004};
      logic [15:0] d;
      for (int i = 0; i < 12; i++)
         wr(adr[i], 16'ha5c3 ^ (16'h0111 * i[15:0]));
      for (int i = 0; i < 12; i++) begin
         rd(adr[i], d);
         chk("register", i == 11 ? 16'h0000 :
            16'ha5c3 ^ (16'h0111 * i[15:0]), d);
      end
   endtask : t_regs

   task automatic t_dirs();
      for (int i = 0; i < 16; i++) begin
         wr(crtv_pkg::ADDR_DISPLAY_CONTROL, 16'h8000 | i[15:0]);
         repeat (6) @(posedge mclk);
         #1;
         chk("pin enables",
            {13'h0, ~(i[2] | i[3]), ~i[1], ~i[0]},
            {13'h0, compSyncOeN, vsyncOeN, hsyncOeN});
      end
   endtask : t_dirs

   // One dot is 8 system cycles; a line of 10 dots is 80.
   task automatic t_timing();
      wr(crtv_pkg::ADDR_DISPLAY_CONTROL, 16'h0000);
      wr(crtv_pkg::ADDR_HORIZ_TOTAL, 16'h0009);
      wr(crtv_pkg::ADDR_HORIZ_SYNC_END, 16'h0001);
      wr(crtv_pkg::ADDR_HORIZ_BLANK_START, 16'h0007);
      wr(crtv_pkg::ADDR_HORIZ_BLANK_END, 16'h0002);
      wr(crtv_pkg::ADDR_VERT_TOTAL, 16'h0004);
      wr(crtv_pkg::ADDR_VERT_SYNC_END, 16'h0001);
      wr(crtv_pkg::ADDR_VERT_BLANK_START, 16'h0003);
      wr(crtv_pkg::ADDR_VERT_BLANK_END, 16'h0001);
      wr(crtv_pkg::ADDR_DISPLAY_CONTROL, 16'h800f);
      measure(0, 16, 80);
      measure(2, 40, 80);
      measure(1, 160, 400);
      measure(3, 240, 400);
   endtask : t_timing

   // Pulses land mid-dot, so no dot tick disturbs the preset before the read.
   task automatic t_external();
      logic [15:0] d;
      int n;
      wr(crtv_pkg::ADDR_HORIZ_PRESET, 16'h0005);
      wr(crtv_pkg::ADDR_VERT_PRESET, 16'h0002);
      wr(crtv_pkg::ADDR_DISPLAY_CONTROL, 16'hc00c);
      repeat (40) @(posedge mclk);
      hReq <= 1'b1;
      wait_lvl(4, 1'b0, n);
      repeat (3) @(posedge mclk);
      rd(crtv_pkg::ADDR_HORIZ_COUNTER, d);
      chk("horiz preset load", 16'h0005, d);
      hReq <= 1'b0;
      repeat (40) @(posedge mclk);
      vReq <= 1'b1;
      wait_lvl(5, 1'b0, n);
      repeat (3) @(posedge mclk);
      rd(crtv_pkg::ADDR_VERT_COUNTER, d);
      chk("vert preset load", 16'h0002, d);
      vReq <= 1'b0;
      wr(crtv_pkg::ADDR_VERT_PRESET, 16'h0000);
      wr(crtv_pkg::ADDR_DISPLAY_CONTROL, 16'h800c);
      repeat (40) @(posedge mclk);
      wr(crtv_pkg::ADDR_VERT_COUNTER, 16'h0001);
      vReq <= 1'b1;
      wait_lvl(5, 1'b0, n);
      repeat (3) @(posedge mclk);
      rd(crtv_pkg::ADDR_VERT_COUNTER, d);
      chk("interlaced preset load", 16'h0000, d);
      vReq <= 1'b0;
   endtask : t_external

   // Serration replaces the composite pulse in the two vertical sync lines.
   task automatic t_composite();
      int a;
      int n;
      wr(crtv_pkg::ADDR_SERRATION_END, 16'h0004);
      wr(crtv_pkg::ADDR_DISPLAY_CONTROL, 16'h8007);
      #1;
      wait_lvl(1, 1'b1, n);
      wait_lvl(1, 1'b0, n);
      wait_lvl(2, 1'b1, a);
      chk("serration width", 16'h0028, a[15:0]);
      wait_lvl(1, 1'b1, n);
      wait_lvl(2, 1'b1, a);
      chk("composite sync width", 16'h0010, a[15:0]);
   endtask : t_composite

   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_disabled();
      t_regs();
      t_dirs();
      t_timing();
      t_external();
      t_composite();
      give_verdict();
   end
endmodule : tb
`default_nettype wire
